/* design/refclk_ctrl_pkg.sv */
// Constants for the reference clock and carrier control block.
// Assumes a single 20 MHz reference clock and a register port on serial pins.
package refclk_ctrl_pkg;

  // Register offsets (7-bit address space)
  localparam logic [6:0] ADDR_OP_MODE     = 7'h01; // Operating mode
  localparam logic [6:0] ADDR_CARRIER_MSB = 7'h07; // Carrier word bits 23:16
  localparam logic [6:0] ADDR_CARRIER_MID = 7'h08; // Carrier word bits 15:8
  localparam logic [6:0] ADDR_CARRIER_LSB = 7'h09; // Carrier word bits 7:0
  localparam logic [6:0] ADDR_IO_MAP_TWO  = 7'h26; // Pin mapping two
  localparam logic [6:0] ADDR_STATUS      = 7'h27; // Block status
  localparam logic [6:0] ADDR_REF_CFG     = 7'h59; // Reference config

  // Field positions
  localparam int MODE_LSB         = 2; // Mode field bits 4:2
  localparam int CLK_SEL_LSB      = 0; // Clock select field bits 2:0
  localparam int EXT_CLK_BIT      = 4; // External clock select bit
  localparam int ST_OSC_READY_BIT = 7; // Status: oscillator stable
  localparam int ST_SYNTH_ON_BIT  = 6; // Status: synthesizer running
  localparam int ST_CAL_BUSY_BIT  = 5; // Status: calibration running
  localparam int ST_COARSE_BIT    = 4; // Status: coarse calibration done

  // Reset values
  localparam logic [2:0] MODE_RESET    = 3'h1; // Standby
  localparam logic [2:0] CLK_SEL_RESET = 3'h0; // Output on, smallest ratio
  localparam logic       EXT_CLK_RESET = 1'b0; // Crystal in use

  // Clock output select encodings: 0..5 divide by 2^(code+1), 6..7 off
  localparam logic [2:0] CLK_SEL_LAST_DIV = 3'h5;
  localparam logic [2:0] CLK_SEL_OFF      = 3'h7;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_SLEEP   = 3'b000,
    MODE_STANDBY = 3'b001,
    MODE_SYNTH   = 3'b010,
    MODE_TX      = 3'b011,
    MODE_RX      = 3'b100
  } op_mode_e;

  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE     = 2'b00,
    SEQ_WAIT_OSC = 2'b01,
    SEQ_FINE_CAL = 2'b10,
    SEQ_RUN      = 2'b11
  } seq_state_e;

  // Timing
  localparam int CLK_PERIOD_NS    = 50;   // 20 MHz reference
  localparam int OSC_STARTUP_US   = 500;  // Worst-case oscillator start
  localparam int FINE_CAL_NS      = 2000; // Fine calibration duration
  localparam int COARSE_CAL_NS    = 4000; // Coarse calibration duration
  localparam int FINE_CAL_CYC     =
    (FINE_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COARSE_CAL_CYC   =
    (COARSE_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_CNT_W        = 8;    // Fits both calibration counts

  // Frequency step exponent of the fractional modulator
  localparam int FRAC_BITS        = 19;
  localparam int CARRIER_W        = 24;

endpackage

/* design/ref_clock_divider.sv */
// Divided reference clock generator feeding the clock output pin.
// Assumes the enable and select come from logic on the same clock.
`timescale 1ns/1ps
module ref_clock_divider (
  input  wire logic       ref_clk_in,  // Reference clock
  input  wire logic       sys_rst_in,  // Async reset, active high
  input  wire logic       enable_in,   // Output allowed
  input  wire logic [2:0] select_in,   // Division code
  output logic            clk_div_out  // Registered divided clock
);
  import refclk_ctrl_pkg::*;

  logic [5:0] count_q;  // Free-running divider chain
  logic [5:0] count_d;
  logic       clk_div_q;
  logic       clk_div_d;

  // Next divider count and gated tap selection
  always_comb begin
    count_d = count_q + 6'h01;
    if (enable_in && select_in <= CLK_SEL_LAST_DIV) begin
      clk_div_d = count_q[select_in];
    end else begin
      clk_div_d = 1'b0; // Off codes and gated periods hold low
    end
  end

  // Register the divider state
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count_q   <= 6'h00;
      clk_div_q <= 1'b0;
    end else begin
      count_q   <= count_d;
      clk_div_q <= clk_div_d;
    end
  end

  assign clk_div_out = clk_div_q;

endmodule // ref_clock_divider

/* design/carrier_freq_ref_clock_control.sv */
// Reference clock and carrier frequency control with its serial register port.
// Assumes serial pins and oscillator status are asynchronous to ref_clk_in.
`timescale 1ns/1ps
module carrier_freq_ref_clock_control (
  input  wire logic        ref_clk_in,           // Reference clock
  input  wire logic        sys_rst_in,           // Async reset, active high
  input  wire logic        spi_nss_n_in,         // Serial select, low active
  input  wire logic        spi_sck_in,           // Serial clock
  input  wire logic        spi_mosi_in,          // Serial data in
  output logic             spi_miso_out,         // Serial data out
  output logic             spi_miso_oe_n_out,    // Low while driving
  input  wire logic        osc_stable_in,        // Oscillator detector
  output logic             ext_clk_select_out,   // Use crystal_in_a clock
  output logic             osc_enable_out,       // Run crystal oscillator
  output logic             coarse_cal_out,       // Coarse VCO calibration
  output logic             fine_cal_out,         // Fine VCO calibration
  output logic             synth_enable_out,     // Synthesizer on
  output logic [refclk_ctrl_pkg::CARRIER_W-1:0]
                           carrier_word_out,     // Applied carrier word
  output logic             carrier_load_out,     // Word applied pulse
  output logic             general_io_five_out,  // Clock output pin
  output logic             general_io_five_oe_n_out // Low while driving
);
  import refclk_ctrl_pkg::*;

  // Two-stage synchronisers for nss, sck, mosi, osc_stable
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic       sck_prev_q;      // Previous synchronised sck
  logic       nss_n;           // Synchronised select
  logic       sck;             // Synchronised clock
  logic       mosi;            // Synchronised data
  logic       osc_ok;          // Synchronised oscillator status

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1_q    <= 4'h1;
      sync2_q    <= 4'h1;
      sck_prev_q <= 1'b0;
    end else begin
      sync1_q    <= {osc_stable_in, spi_mosi_in, spi_sck_in, spi_nss_n_in};
      sync2_q    <= sync1_q;
      sck_prev_q <= sync2_q[1];
    end
  end

  assign nss_n  = sync2_q[0];
  assign sck    = sync2_q[1];
  assign mosi   = sync2_q[2];
  assign osc_ok = sync2_q[3];

  // Serial frame state
  logic [2:0] bit_cnt_q, bit_cnt_d;   // Bit index within byte
  logic [7:0] rx_q, rx_d;             // Incoming shift register
  logic [7:0] tx_q, tx_d;             // Outgoing byte
  logic [6:0] addr_q, addr_d;         // Current register address
  logic       wr_q, wr_d;             // Frame is a write
  logic       first_q, first_d;       // Next byte is the address
  logic       miso_q, miso_d;         // Registered data out
  logic       miso_oe_n_q, miso_oe_n_d;

  // Register file
  logic [2:0] mode_q, mode_d;         // Operating mode
  logic [2:0] clk_sel_q, clk_sel_d;   // clock_output_select
  logic       ext_clk_q, ext_clk_d;   // External reference select
  logic [7:0] msb_shadow_q, msb_shadow_d;   // Buffered upper byte
  logic [7:0] mid_shadow_q, mid_shadow_d;   // Buffered middle byte
  logic [CARRIER_W-1:0] carrier_q, carrier_d; // Applied word
  logic       load_q, load_d;         // Applied-word pulse

  logic       sck_rise;               // Sampling edge
  logic       sck_fall;               // Shifting edge
  logic [7:0] byte_in;                // Completed byte
  logic       byte_done;              // Byte completes this cycle
  logic [6:0] rd_addr;                // Address for the next read load
  logic [7:0] rd_data;                // Read mux output
  logic [7:0] status;                 // Live status byte
  logic       coarse_done_q, coarse_done_d;
  seq_state_e seq_q, seq_d;

  assign sck_rise  = sck & ~sck_prev_q & ~nss_n;
  assign sck_fall  = ~sck & sck_prev_q & ~nss_n;
  assign byte_in   = {rx_q[6:0], mosi};
  assign byte_done = sck_rise && (bit_cnt_q == 3'h7);

  // Status byte shows the block's own state
  always_comb begin
    status                   = 8'h00;
    status[ST_OSC_READY_BIT] = osc_ok;
    status[ST_SYNTH_ON_BIT]  = (seq_q == SEQ_RUN);
    status[ST_CAL_BUSY_BIT]  = (seq_q == SEQ_FINE_CAL) || !coarse_done_q;
    status[ST_COARSE_BIT]    = coarse_done_q;
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_addr = first_q ? byte_in[6:0] : addr_q + 7'h01;
    rd_data = 8'h00;
    case (rd_addr)
      ADDR_OP_MODE:     rd_data[MODE_LSB +: 3]    = mode_q;
      ADDR_CARRIER_MSB: rd_data = msb_shadow_q;
      ADDR_CARRIER_MID: rd_data = mid_shadow_q;
      ADDR_CARRIER_LSB: rd_data = carrier_q[7:0];
      ADDR_IO_MAP_TWO:  rd_data[CLK_SEL_LSB +: 3] = clk_sel_q;
      ADDR_STATUS:      rd_data = status;
      ADDR_REF_CFG:     rd_data[EXT_CLK_BIT]      = ext_clk_q;
      default:          rd_data = 8'h00;
    endcase
  end

  // Next state of the serial port and the register file
  always_comb begin
    bit_cnt_d    = bit_cnt_q;
    rx_d         = rx_q;
    tx_d         = tx_q;
    addr_d       = addr_q;
    wr_d         = wr_q;
    first_d      = first_q;
    miso_d       = miso_q;
    miso_oe_n_d  = nss_n;
    mode_d       = mode_q;
    clk_sel_d    = clk_sel_q;
    ext_clk_d    = ext_clk_q;
    msb_shadow_d = msb_shadow_q;
    mid_shadow_d = mid_shadow_q;
    carrier_d    = carrier_q;
    load_d       = 1'b0;
    if (nss_n) begin
      // Idle between frames: restart at the address byte
      bit_cnt_d = 3'h0;
      first_d   = 1'b1;
      miso_d    = 1'b0;
    end else if (sck_rise) begin
      rx_d      = byte_in;
      bit_cnt_d = bit_cnt_q + 3'h1;
      if (byte_done) begin
        tx_d = rd_data;
        if (first_q) begin
          // Address byte: bit 7 high means write
          addr_d  = byte_in[6:0];
          wr_d    = byte_in[7];
          first_d = 1'b0;
        end else begin
          addr_d = addr_q + 7'h01; // Burst advances the address
          if (wr_q) begin
            case (addr_q)
              ADDR_OP_MODE:     mode_d       = byte_in[MODE_LSB +: 3];
              ADDR_CARRIER_MSB: msb_shadow_d = byte_in;
              ADDR_CARRIER_MID: mid_shadow_d = byte_in;
              ADDR_CARRIER_LSB: begin
                carrier_d = {msb_shadow_q, mid_shadow_q, byte_in};
                load_d    = 1'b1;
              end
              ADDR_IO_MAP_TWO:  clk_sel_d    = byte_in[CLK_SEL_LSB +: 3];
              ADDR_REF_CFG:     ext_clk_d    = byte_in[EXT_CLK_BIT];
              default:          ; // Writes to other addresses are dropped
            endcase
          end
        end
      end
    end else if (sck_fall) begin
      miso_d = tx_q[3'h7 - bit_cnt_q];
    end
  end

  // Register the serial port and the register file
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bit_cnt_q    <= 3'h0;
      rx_q         <= 8'h00;
      tx_q         <= 8'h00;
      addr_q       <= 7'h00;
      wr_q         <= 1'b0;
      first_q      <= 1'b1;
      miso_q       <= 1'b0;
      miso_oe_n_q  <= 1'b1;
      mode_q       <= MODE_RESET;
      clk_sel_q    <= CLK_SEL_RESET;
      ext_clk_q    <= EXT_CLK_RESET;
      msb_shadow_q <= 8'h00;
      mid_shadow_q <= 8'h00;
      carrier_q    <= '0;
      load_q       <= 1'b0;
    end else begin
      bit_cnt_q    <= bit_cnt_d;
      rx_q         <= rx_d;
      tx_q         <= tx_d;
      addr_q       <= addr_d;
      wr_q         <= wr_d;
      first_q      <= first_d;
      miso_q       <= miso_d;
      miso_oe_n_q  <= miso_oe_n_d;
      mode_q       <= mode_d;
      clk_sel_q    <= clk_sel_d;
      ext_clk_q    <= ext_clk_d;
      msb_shadow_q <= msb_shadow_d;
      mid_shadow_q <= mid_shadow_d;
      carrier_q    <= carrier_d;
      load_q       <= load_d;
    end
  end

  // Sequencer and calibration state
  logic [CAL_CNT_W-1:0] cal_cnt_q, cal_cnt_d;     // Fine cal timer
  logic [CAL_CNT_W-1:0] coarse_cnt_q, coarse_cnt_d; // Coarse cal timer
  logic       fine_pulse_q, fine_pulse_d;
  logic       coarse_pulse_q, coarse_pulse_d;
  logic       coarse_started_q, coarse_started_d;
  logic       synth_mode;             // Mode needs the synthesizer
  logic       osc_en_q, osc_en_d;
  logic       synth_en_q, synth_en_d;

  assign synth_mode = (mode_q == MODE_SYNTH) || (mode_q == MODE_TX) ||
                      (mode_q == MODE_RX);

  // Next sequencer state
  always_comb begin
    seq_d            = seq_q;
    cal_cnt_d        = cal_cnt_q;
    fine_pulse_d     = 1'b0;
    coarse_pulse_d   = 1'b0;
    coarse_cnt_d     = coarse_cnt_q;
    coarse_started_d = coarse_started_q;
    coarse_done_d    = coarse_done_q;
    // Oscillator runs outside Sleep unless an external clock is used
    osc_en_d = (mode_q != MODE_SLEEP) && !ext_clk_q;
    // One coarse calibration after reset, once the reference is stable
    if (!coarse_started_q && osc_ok) begin
      coarse_started_d = 1'b1;
      coarse_pulse_d   = 1'b1;
      coarse_cnt_d     = CAL_CNT_W'(COARSE_CAL_CYC - 1);
    end else if (coarse_started_q && !coarse_done_q) begin
      if (coarse_cnt_q == '0) begin
        coarse_done_d = 1'b1;
      end else begin
        coarse_cnt_d = coarse_cnt_q - 1'b1;
      end
    end
    case (seq_q)
      SEQ_IDLE: begin
        if (synth_mode) begin
          seq_d = SEQ_WAIT_OSC;
        end
      end
      SEQ_WAIT_OSC: begin
        if (!synth_mode) begin
          seq_d = SEQ_IDLE;
        end else if (osc_ok && coarse_done_q) begin
          // Start without host command once the reference is stable and coarse calibration is done
          seq_d        = SEQ_FINE_CAL;
          fine_pulse_d = 1'b1;
          cal_cnt_d    = CAL_CNT_W'(FINE_CAL_CYC - 1);
        end
      end
      SEQ_FINE_CAL: begin
        if (!synth_mode) begin
          seq_d = SEQ_IDLE;
        end else if (cal_cnt_q == '0) begin
          seq_d = SEQ_RUN;
        end else begin
          cal_cnt_d = cal_cnt_q - 1'b1;
        end
      end
      SEQ_RUN: begin
        if (!synth_mode || !osc_ok) begin
          seq_d = SEQ_IDLE; // Each reactivation recalibrates
        end
      end
      default: seq_d = SEQ_IDLE;
    endcase
    synth_en_d = (seq_d == SEQ_RUN);
  end

  // Register the sequencer
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      seq_q            <= SEQ_IDLE;
      cal_cnt_q        <= '0;
      coarse_cnt_q     <= '0;
      fine_pulse_q     <= 1'b0;
      coarse_pulse_q   <= 1'b0;
      coarse_started_q <= 1'b0;
      coarse_done_q    <= 1'b0;
      osc_en_q         <= 1'b0;
      synth_en_q       <= 1'b0;
    end else begin
      seq_q            <= seq_d;
      cal_cnt_q        <= cal_cnt_d;
      coarse_cnt_q     <= coarse_cnt_d;
      fine_pulse_q     <= fine_pulse_d;
      coarse_pulse_q   <= coarse_pulse_d;
      coarse_started_q <= coarse_started_d;
      coarse_done_q    <= coarse_done_d;
      osc_en_q         <= osc_en_d;
      synth_en_q       <= synth_en_d;
    end
  end

  // Clock output gating: stable reference, not Sleep, not switched off
  logic clk_out_en;
  logic pin_oe_n_q, pin_oe_n_d;

  assign clk_out_en = osc_ok && (mode_q != MODE_SLEEP) &&
                      (clk_sel_q <= CLK_SEL_LAST_DIV);

  always_comb begin
    pin_oe_n_d = !clk_out_en;
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_oe_n_q <= 1'b1;
    end else begin
      pin_oe_n_q <= pin_oe_n_d;
    end
  end

  // Divided reference for general_io_five
  ref_clock_divider u_divider (
    .ref_clk_in  (ref_clk_in),
    .sys_rst_in  (sys_rst_in),
    .enable_in   (clk_out_en),
    .select_in   (clk_sel_q),
    .clk_div_out (general_io_five_out)
  );

  // Outputs straight from flip-flops
  assign spi_miso_out             = miso_q;
  assign spi_miso_oe_n_out        = miso_oe_n_q;
  assign ext_clk_select_out       = ext_clk_q;
  assign osc_enable_out           = osc_en_q;
  assign coarse_cal_out           = coarse_pulse_q;
  assign fine_cal_out             = fine_pulse_q;
  assign synth_enable_out         = synth_en_q;
  assign carrier_word_out         = carrier_q;
  assign carrier_load_out         = load_q;
  assign general_io_five_oe_n_out = pin_oe_n_q;

endmodule // carrier_freq_ref_clock_control

/* test/refclk_ctrl_properties.sv */
// Checker for the reference clock and carrier word block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ps
module refclk_ctrl_checker (
  input wire logic ref_clk_in,               // Clock
  input wire logic sys_rst_in,               // Async reset
  input wire logic spi_nss_n_in,             // Serial select
  input wire logic spi_sck_in,               // Serial clock
  input wire logic spi_mosi_in,              // Serial data in
  input wire logic spi_miso_out,             // Serial data out
  input wire logic spi_miso_oe_n_out,        // Data out enable
  input wire logic osc_stable_in,            // Oscillator stable
  input wire logic ext_clk_select_out,       // External clock
  input wire logic osc_enable_out,           // Oscillator on
  input wire logic coarse_cal_out,           // Coarse pulse
  input wire logic fine_cal_out,             // Fine pulse
  input wire logic synth_enable_out,         // Synthesizer on
  input wire logic [refclk_ctrl_pkg::CARRIER_W-1:0]
                   carrier_word_out,         // Applied word
  input wire logic carrier_load_out,         // Word applied
  input wire logic general_io_five_out,      // Clock pin
  input wire logic general_io_five_oe_n_out  // Clock pin enable
);
  import refclk_ctrl_pkg::*;
  logic       coarse_seen_q, coarse_seen_d; // Coarse pulse seen
  logic [7:0] since_fine_q, since_fine_d;   // Cycles since fine pulse
  // Next values of the helper state, count saturates
  always_comb begin
    coarse_seen_d = coarse_seen_q | coarse_cal_out;
    since_fine_d  = since_fine_q + {7'h00, (since_fine_q != 8'hff)};
    if (fine_cal_out) begin
      since_fine_d = 8'h01;
    end
  end
  // Helper registers
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      coarse_seen_q <= 1'b0;
      since_fine_q  <= 8'hff;
    end else begin
      coarse_seen_q <= coarse_seen_d;
      since_fine_q  <= since_fine_d;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Lasting conditions
  sequence s_unstable; !osc_stable_in [*6]; endsequence
  sequence s_sleeping; (!osc_enable_out && !ext_clk_select_out) [*4];
  endsequence
  sequence s_bus_idle; spi_nss_n_in [*4]; endsequence
  property p_unstable_off; s_unstable |-> general_io_five_oe_n_out;
  endproperty
  property p_sleep_off; s_sleeping |-> general_io_five_oe_n_out;
  endproperty
  property p_ext_no_osc; ext_clk_select_out [*2] |-> !osc_enable_out;
  endproperty
  property p_coarse_once; coarse_cal_out |-> !coarse_seen_q; endproperty
  property p_fine_ready;
    fine_cal_out |-> coarse_seen_q && !synth_enable_out;
  endproperty
  property p_synth_delay;
    $rose(synth_enable_out) |->
      since_fine_q >= 8'h28 && since_fine_q <= 8'h2a;
  endproperty
  property p_load_pulse; carrier_load_out |=> !carrier_load_out;
  endproperty
  property p_word_stable;
    !carrier_load_out && !$past(carrier_load_out) |->
      $stable(carrier_word_out);
  endproperty
  property p_load_in_frame; carrier_load_out |-> !$past(spi_nss_n_in, 5);
  endproperty
  property p_miso_idle; s_bus_idle |-> spi_miso_oe_n_out; endproperty
  a_unstable_off: assert property (p_unstable_off)
    else $error("clock out while unstable");
  a_sleep_off: assert property (p_sleep_off)
    else $error("clock out in sleep");
  a_ext_no_osc: assert property (p_ext_no_osc)
    else $error("oscillator on with external clock");
  a_coarse_once: assert property (p_coarse_once)
    else $error("second coarse calibration");
  a_fine_ready: assert property (p_fine_ready)
    else $error("misplaced fine calibration");
  a_synth_delay: assert property (p_synth_delay)
    else $error("synth start delay wrong");
  a_load_pulse: assert property (p_load_pulse)
    else $error("load pulse too long");
  a_word_stable: assert property (p_word_stable)
    else $error("word changed without load");
  a_load_in_frame: assert property (p_load_in_frame)
    else $error("load outside a frame");
  a_miso_idle: assert property (p_miso_idle)
    else $error("data out driven while idle");
endmodule // refclk_ctrl_checker

bind carrier_freq_ref_clock_control refclk_ctrl_checker u_refclk_ctrl_checker (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
  .spi_nss_n_in(spi_nss_n_in), .spi_sck_in(spi_sck_in),
  .spi_mosi_in(spi_mosi_in), .spi_miso_out(spi_miso_out),
  .spi_miso_oe_n_out(spi_miso_oe_n_out), .osc_stable_in(osc_stable_in),
  .ext_clk_select_out(ext_clk_select_out), .osc_enable_out(osc_enable_out),
  .coarse_cal_out(coarse_cal_out), .fine_cal_out(fine_cal_out),
  .synth_enable_out(synth_enable_out), .carrier_word_out(carrier_word_out),
  .carrier_load_out(carrier_load_out),
  .general_io_five_out(general_io_five_out),
  .general_io_five_oe_n_out(general_io_five_oe_n_out));

/* test/spi_host_model.sv */
// Host model driving the serial register port in mode 0, MSB first.
// Assumes the block oversamples the serial pins on ref_clk_in.
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic ref_clk_in, // Pacing clock
  input  wire logic miso_in,    // Data from the block
  output logic      nss_n_out,  // Select, low active
  output logic      sck_out,    // Serial clock, idle low
  output logic      mosi_out    // Data to the block
);
  localparam int HALF = 6; // Clocks per phase, above minimum
  // Idle bus at time zero
  initial begin
    nss_n_out = 1'b1;
    sck_out   = 1'b0;
    mosi_out  = 1'b0;
  end
  // One sck phase, changes land on falling clock edges
  task automatic tick();
    repeat (HALF) @(negedge ref_clk_in);
  endtask
  // Address byte then nb data bytes; rd collects the data phase
  task automatic xfer(input logic wr, input logic [6:0] addr,
                      input logic [23:0] wd, input int nb,
                      output logic [23:0] rd);
    logic [31:0] sh;
    sh = {wr, addr, wd << (8 * (3 - nb))};
    rd = '0;
    @(negedge ref_clk_in);
    nss_n_out = 1'b0;
    for (int i = 0; i < 8 * (nb + 1); i++) begin
      mosi_out = sh[31-i];
      tick();
      if (i >= 8) rd = {rd[22:0], miso_in};
      sck_out = 1'b1;
      tick();
      sck_out = 1'b0;
    end
    tick();
    nss_n_out = 1'b1;
    mosi_out  = ~mosi_out; // Released line shows no stale value
    tick();
  endtask
endmodule // spi_host_model

/* test/tb_carrier_freq_ref_clock_control.sv */
// Self-checking bench for the reference clock and carrier word block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_carrier_freq_ref_clock_control;
  import refclk_ctrl_pkg::*;
  logic        ref_clk, rst, osc_stable, nss_n, sck, mosi, miso;
  logic        miso_oe_n, ext_sel, osc_en, coarse, fine, synth_en, miso_out;
  logic        load, gio5, gio5_oe_n; // Design outputs
  logic [23:0] word, rd, w; // Carrier and read data
  logic [23:0] exp_q[$]; // Expected loads
  logic [31:0] lfsr; // Random source
  int          mismatches, checked, coarse_cnt, fine_cnt, p;
  // Released data line shows the inverse of mosi
  assign miso = miso_oe_n ? ~mosi : miso_out;
  spi_host_model u_spi_host_model (.ref_clk_in(ref_clk), .miso_in(miso),
    .nss_n_out(nss_n), .sck_out(sck), .mosi_out(mosi));
  carrier_freq_ref_clock_control u_carrier_freq_ref_clock_control (
    .ref_clk_in(ref_clk), .sys_rst_in(rst), .spi_nss_n_in(nss_n),
    .spi_sck_in(sck), .spi_mosi_in(mosi), .spi_miso_out(miso_out),
    .spi_miso_oe_n_out(miso_oe_n), .osc_stable_in(osc_stable),
    .ext_clk_select_out(ext_sel), .osc_enable_out(osc_en),
    .coarse_cal_out(coarse), .fine_cal_out(fine),
    .synth_enable_out(synth_en), .carrier_word_out(word),
    .carrier_load_out(load), .general_io_five_out(gio5),
    .general_io_five_oe_n_out(gio5_oe_n));
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Register access through the host model
  task automatic wr(input logic [6:0] a, input logic [23:0] d, input int n);
    u_spi_host_model.xfer(1'b1, a, d, n, rd);
  endtask
  task automatic rd_reg(input logic [6:0] a, input int n);
    u_spi_host_model.xfer(1'b0, a, 24'h0, n, rd);
  endtask
  // Bounded wait: 0 synthesizer on, 1 clock pin driven
  task automatic wait_until(input int sel, input int lim);
    int n = 0;
    while (!(sel == 0 ? synth_en === 1'b1 : gio5_oe_n === 1'b0)) begin
      @(negedge ref_clk);
      n++;
      if (n > lim) begin
        check("bounded wait", 32'(sel), 32'hffffffff);
        conclude();
      end
    end
  endtask
  // Cycles between two rising edges of the clock pin, 0 if none
  task automatic period(output int per);
    int t0 = -1;
    logic prev;
    per = 0;
    prev = gio5;
    for (int n = 0; n < 300 && per == 0; n++) begin
      @(negedge ref_clk);
      if (gio5 === 1'b1 && prev === 1'b0) begin
        if (t0 >= 0) per = n - t0;
        t0 = n;
      end
      prev = gio5;
    end
  endtask
  // Clock source
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Watchdog against a hang
  initial begin
    repeat (90000) @(posedge ref_clk);
    check("run length", 32'h1, 32'h0);
    conclude();
  end
  // Output monitor: pulses counted, loads matched to oldest note
  always @(negedge ref_clk) begin
    if (coarse === 1'b1) coarse_cnt++;
    if (fine === 1'b1) fine_cnt++;
    if (load === 1'b1 && exp_q.size() == 0) check("load", 1, 0);
    else if (load === 1'b1) check("word", 32'(word), exp_q.pop_front());
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    osc_stable = 1'b0;
    lfsr = 32'h729db339;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    repeat (20) @(negedge ref_clk);
    check("clock pin unstable", gio5_oe_n, 1);
    osc_stable = 1'b1;
    wait_until(1, 12);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_IO_MAP_TWO, 24'(c), 1);
      period(p);
      check("clock period", p, c < 6 ? 2 << c : 0);
      check("clock pin off", gio5_oe_n, c > 5);
    end
    wr(ADDR_IO_MAP_TWO, 24'(CLK_SEL_RESET), 1);
    wr(ADDR_OP_MODE, 24'(MODE_SLEEP) << MODE_LSB, 1);
    repeat (6) @(negedge ref_clk);
    check("sleep clock pin", gio5_oe_n, 1);
    wr(ADDR_OP_MODE, 24'(MODE_STANDBY) << MODE_LSB, 1);
    wait_until(1, 12);
    osc_stable = 1'b0;
    repeat (8) @(negedge ref_clk);
    check("lost oscillator", gio5_oe_n, 1);
    osc_stable = 1'b1;
    check("coarse pulses", coarse_cnt, 1);
    for (int m = 2; m < 5; m++) begin
      wr(ADDR_OP_MODE, 24'(m << MODE_LSB), 1);
      wait_until(0, 80);
      check("fine pulses", fine_cnt, m - 1);
      wr(ADDR_OP_MODE, 24'(MODE_STANDBY) << MODE_LSB, 1);
      check("synth off", synth_en, 0);
    end
    rd_reg(ADDR_STATUS, 1);
    check("status", rd, 24'h90);
    wr(ADDR_REF_CFG, 24'h10, 1);
    rd_reg(ADDR_REF_CFG, 1);
    check("ext readback", rd, 24'h10);
    check("ext select", {ext_sel, osc_en}, 2'b10);
    wr(ADDR_REF_CFG, 24'h0, 1);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      w = lfsr[23:0];
      if (i[0]) begin
        exp_q.push_back(w);
        wr(ADDR_CARRIER_MSB, w, 3);
      end else begin
        p = 32'(word);
        wr(ADDR_CARRIER_MSB, w >> 16, 1);
        wr(ADDR_CARRIER_MID, w >> 8, 1);
        check("word held", word, p);
        exp_q.push_back(w);
        wr(ADDR_CARRIER_LSB, w, 1);
      end
      rd_reg(ADDR_CARRIER_MSB, 3);
      check("word readback", rd, w);
    end
    check("loads seen", exp_q.size(), 0);
    wr(7'h60, 24'ha5, 1);
    rd_reg(7'h60, 1);
    check("unmapped read", rd, 0);
    wr(ADDR_IO_MAP_TWO, 24'(CLK_SEL_OFF), 1);
    check("clock pin disabled", gio5_oe_n, 1);
    conclude();
  end
endmodule // tb_carrier_freq_ref_clock_control
